//--- core/pcr_pkg.sv
package pcr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register word indices on the plain register port
  localparam logic [2:0] PCR_ADDR_LOOP_CTRL = 3'h0;
  localparam logic [2:0] PCR_ADDR_BANDWIDTH = 3'h1;
  localparam logic [2:0] PCR_ADDR_DIV_HIGH  = 3'h2;
  localparam logic [2:0] PCR_ADDR_DIV_LOW   = 3'h3;
  localparam logic [2:0] PCR_ADDR_VCO_RANGE = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // Loop control register fields
  localparam int PCR_CTL_IRQ_EN   = 7;
  localparam int PCR_CTL_IRQ_FLAG = 6;
  localparam int PCR_CTL_POWER_ON = 5;
  localparam int PCR_CTL_BASE_SEL = 4;
  localparam int PCR_CTL_VPR_HI   = 1;
  localparam int PCR_CTL_VPR_LO   = 0;

  // Bandwidth control register fields
  localparam int PCR_BW_AUTO  = 7;
  localparam int PCR_BW_LOCK  = 6;
  localparam int PCR_BW_TRACK = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and special codes
  localparam logic       PCR_RST_POWER_ON  = 1'b1;
  localparam logic [1:0] PCR_RST_VPR       = 2'h0;
  localparam logic [3:0] PCR_RST_DIV_HIGH  = 4'h0;
  localparam logic [7:0] PCR_RST_DIV_LOW   = 8'h40;
  localparam logic [7:0] PCR_RST_VCO_RANGE = 8'h40;
  localparam logic [7:0] PCR_LINEAR_OFF    = 8'h00;
  localparam logic [11:0] PCR_DIV_ZERO     = 12'h000;
  localparam logic [11:0] PCR_DIV_ONE      = 12'h001;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: source edges each side must show before the base clock switches
  localparam int PCR_SWITCH_EDGES = 3;

  typedef enum logic {PCR_SW_RUN, PCR_SW_HOLD} pcr_sw_state_t;

endpackage : pcr_pkg

//--- core/pcr_bank.sv
`timescale 1ns/10ps
`default_nettype none

module pcr_bank
  import pcr_pkg::*;
#(
  parameter int SWITCH_EDGES = PCR_SWITCH_EDGES
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [2:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        locked_i,
  input  wire logic        loop_track_i,
  input  wire logic        crystal_clock_i,
  input  wire logic        vco_clock_i,
  output logic             base_clock_out_o,
  output logic             base_source_o,
  output logic             loop_irq_o,
  output logic             loop_enable_o,
  output logic             vco_enable_o,
  output logic             auto_mode_o,
  output logic             capture_or_track_o,
  output logic      [1:0]  vco_range_power_two_o,
  output logic      [11:0] feedback_divider_o,
  output logic      [7:0]  vco_linear_range_o
);

  // The edge counters are three bits wide, so larger counts cannot be served
  if (SWITCH_EDGES < 1 || SWITCH_EDGES > 7)
  begin : g_bad_edges
    $error("SWITCH_EDGES must lie between 1 and 7");
  end

  // Filtered value follows the input once the second and third stages agree
  function automatic logic filt_next(input logic s2, input logic s3, input logic f);
    filt_next = (s2 == s3) ? s3 : f;
  endfunction : filt_next

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers for pins from outside the clock domain
  logic [2:0] lock_sync;
  logic [2:0] track_sync;
  logic [2:0] xtal_sync;
  logic [2:0] vco_sync;
  logic       lock_f;
  logic       track_f;
  logic       xtal_f;
  logic       vco_f;
  logic       next_lock_f;
  logic       next_xtal_f;
  logic       next_vco_f;

  assign next_lock_f = filt_next(lock_sync[1], lock_sync[2], lock_f);
  assign next_xtal_f = filt_next(xtal_sync[1], xtal_sync[2], xtal_f);
  assign next_vco_f  = filt_next(vco_sync[1], vco_sync[2], vco_f);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lock_sync  <= 3'h0;
      track_sync <= 3'h0;
      xtal_sync  <= 3'h0;
      vco_sync   <= 3'h0;
      lock_f     <= 1'b0;
      track_f    <= 1'b0;
      xtal_f     <= 1'b0;
      vco_f      <= 1'b0;
    end
    else
    begin
      lock_sync  <= {lock_sync[1:0], locked_i};
      track_sync <= {track_sync[1:0], loop_track_i};
      xtal_sync  <= {xtal_sync[1:0], crystal_clock_i};
      vco_sync   <= {vco_sync[1:0], vco_clock_i};
      lock_f     <= next_lock_f;
      track_f    <= filt_next(track_sync[1], track_sync[2], track_f);
      xtal_f     <= next_xtal_f;
      vco_f      <= next_vco_f;
    end
  end

  wire lock_change = next_lock_f != lock_f;
  wire xtal_rise   = next_xtal_f & ~xtal_f;
  wire vco_rise    = next_vco_f & ~vco_f;

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic       irq_en;
  logic       irq_flag;
  logic       power_on;
  logic       base_sel;
  logic [1:0] vpr;
  logic       auto_mode;
  logic       acq_manual;
  logic [3:0] div_high;
  logic [7:0] div_low;
  logic [7:0] lin_range;

  wire wr_ctl  = wr_i && addr_i == PCR_ADDR_LOOP_CTRL;
  wire wr_bw   = wr_i && addr_i == PCR_ADDR_BANDWIDTH;
  wire wr_divh = wr_i && addr_i == PCR_ADDR_DIV_HIGH;
  wire wr_divl = wr_i && addr_i == PCR_ADDR_DIV_LOW;
  wire wr_vrs  = wr_i && addr_i == PCR_ADDR_VCO_RANGE;
  wire rd_ctl  = rd_i && addr_i == PCR_ADDR_LOOP_CTRL;

  wire range_off = lin_range == PCR_LINEAR_OFF;

  // Protection interlocks act on the values present before the write
  wire next_irq_en = wr_ctl ? (auto_mode & wdata_i[PCR_CTL_IRQ_EN])
                            : (irq_en & auto_mode);
  // Power-on may not drop while the VCO drives the base clock
  wire next_power_on = (wr_ctl && !base_sel) ? wdata_i[PCR_CTL_POWER_ON]
                                              : power_on;
  wire sel_write = wr_ctl ? (wdata_i[PCR_CTL_BASE_SEL] & power_on)
                          : base_sel;
  wire next_base_sel = sel_write & ~range_off;
  // Event set wins over the read that clears the flag in the same cycle
  wire next_irq_flag = (auto_mode & lock_change) | (irq_flag & ~rd_ctl);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_en     <= 1'b0;
      irq_flag   <= 1'b0;
      power_on   <= PCR_RST_POWER_ON;
      base_sel   <= 1'b0;
      vpr        <= PCR_RST_VPR;
      auto_mode  <= 1'b0;
      acq_manual <= 1'b0;
      div_high   <= PCR_RST_DIV_HIGH;
      div_low    <= PCR_RST_DIV_LOW;
      lin_range  <= PCR_RST_VCO_RANGE;
    end
    else
    begin
      irq_en   <= next_irq_en;
      irq_flag <= next_irq_flag;
      power_on <= next_power_on;
      base_sel <= next_base_sel;
      if (wr_ctl && !power_on)
        vpr <= wdata_i[PCR_CTL_VPR_HI:PCR_CTL_VPR_LO];
      if (wr_bw)
        auto_mode <= wdata_i[PCR_BW_AUTO];
      // In automatic mode the manual value is kept untouched for later
      if (wr_bw && !auto_mode)
        acq_manual <= wdata_i[PCR_BW_TRACK];
      if (wr_divh && !power_on)
        div_high <= wdata_i[3:0];
      if (wr_divl && !power_on)
        div_low <= wdata_i;
      if (wr_vrs && !power_on)
        lin_range <= wdata_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; the lock test bit is never stored, writes to it are dropped
  wire        lock_status = auto_mode & lock_f;
  wire        track_eff   = auto_mode ? track_f : acq_manual;
  wire        flag_view   = auto_mode & irq_flag;
  wire [7:0]  ctl_view    = {irq_en, flag_view, power_on, base_sel, 2'h0, vpr};
  wire [7:0]  bw_view     = {auto_mode, lock_status, track_eff, 5'h00};
  wire [11:0] div_raw     = {div_high, div_low};
  logic [7:0] rd_mux;

  always_comb
  begin
    case (addr_i)
      PCR_ADDR_LOOP_CTRL: rd_mux = ctl_view;
      PCR_ADDR_BANDWIDTH: rd_mux = bw_view;
      PCR_ADDR_DIV_HIGH:  rd_mux = {4'h0, div_high};
      PCR_ADDR_DIV_LOW:   rd_mux = div_low;
      PCR_ADDR_VCO_RANGE: rd_mux = lin_range;
      default:            rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rd_mux;
    else
      rdata_o <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Glitch-free base clock selector
  pcr_sw_state_t sw_state;
  logic          active_sel;
  logic [2:0]    xtal_cnt;
  logic [2:0]    vco_cnt;
  logic          base_q;

  localparam logic [2:0] EDGES = 3'(SWITCH_EDGES);

  // A stopped VCO never produces edges, so it may not stall the switch
  wire vco_done  = (vco_cnt >= EDGES) || !loop_enable_o;
  wire xtal_done = xtal_cnt >= EDGES;
  wire src_rise  = active_sel ? vco_rise : xtal_rise;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sw_state   <= PCR_SW_RUN;
      active_sel <= 1'b0;
      xtal_cnt   <= 3'h0;
      vco_cnt    <= 3'h0;
      base_q     <= 1'b0;
    end
    else
    begin
      case (sw_state)
        PCR_SW_RUN:
        begin
          xtal_cnt <= 3'h0;
          vco_cnt  <= 3'h0;
          if (base_sel != active_sel)
            sw_state <= PCR_SW_HOLD;
          else if (src_rise)
            base_q <= ~base_q;
        end
        PCR_SW_HOLD:
        begin
          // Output stays frozen until both sources have been seen, or only the crystal while the loop is disabled
          if (xtal_rise && !xtal_done)
            xtal_cnt <= xtal_cnt + 3'h1;
          if (vco_rise && !vco_done)
            vco_cnt <= vco_cnt + 3'h1;
          if (xtal_done && vco_done)
          begin
            active_sel <= base_sel;
            sw_state   <= PCR_SW_RUN;
          end
        end
        default:
          sw_state <= PCR_SW_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs toward the analog loop
  assign base_clock_out_o      = base_q;
  assign base_source_o         = active_sel;
  assign loop_irq_o            = irq_flag & irq_en & auto_mode;
  assign loop_enable_o         = power_on & ~range_off;
  assign vco_enable_o          = loop_enable_o;
  assign auto_mode_o           = auto_mode;
  assign capture_or_track_o    = track_eff;
  // Code 3 is passed through unchanged; software must not program it
  assign vco_range_power_two_o = vpr;
  assign feedback_divider_o    = (div_raw == PCR_DIV_ZERO) ? PCR_DIV_ONE
                                                           : div_raw;
  assign vco_linear_range_o    = lin_range;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  irq_en_manual_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !auto_mode |-> ##1 (!auto_mode |-> !irq_en))
    else $error("interrupt enable held in manual mode");

  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_mode && lock_change) |=> irq_flag)
    else $error("lock change did not set the flag");

  // A lock change with the request enabled must reach the request output
  irq_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_mode && irq_en && lock_change && !wr_ctl && !wr_bw) |=> loop_irq_o)
    else $error("interrupt request mismatch");

  flag_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_ctl && !auto_mode) |=> !rdata_o[PCR_CTL_IRQ_FLAG])
    else $error("flag visible in manual mode");

  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_ctl && !lock_change) |=> !irq_flag)
    else $error("control read did not clear flag");

  power_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    base_sel |=> power_on)
    else $error("power dropped while VCO selected");

  sel_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!power_on && !base_sel) |=> !base_sel)
    else $error("base select set while power off");

  range_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    range_off |=> (!base_sel && !loop_enable_o))
    else $error("zero range did not stop loop");

  freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (sw_state == PCR_SW_HOLD) |=> $stable(base_q))
    else $error("base clock moved during switch");

  prot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    power_on |=> ($stable(div_low) && $stable(div_high) && $stable(lin_range)))
    else $error("protected field written while powered");

  // Range code must not shift under a running loop
  vpr_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    power_on |=> $stable(vpr))
    else $error("power-of-two code written while powered");

  acq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    auto_mode |=> $stable(acq_manual))
    else $error("held capture value changed in auto mode");

endmodule : pcr_bank

`default_nettype wire

//--- tb/tb_pcr_bank.sv
`timescale 1ns/10ps
`default_nettype none

module tb_pcr_bank
  import pcr_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic [2:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic        locked_i;
  logic        loop_track_i;
  logic        crystal_clock_i;
  logic        vco_clock_i;
  logic        base_clock_out_o;
  logic        base_source_o;
  logic        loop_irq_o;
  logic        loop_enable_o;
  logic        vco_enable_o;
  logic        auto_mode_o;
  logic        capture_or_track_o;
  logic [1:0]  vco_range_power_two_o;
  logic [11:0] feedback_divider_o;
  logic [7:0]  vco_linear_range_o;
  logic [7:0]  expq[$];
  logic        rd_seen;
  logic [2:0]  xc;
  logic [2:0]  vc;
  logic [31:0] seed;
  logic [11:0] d;
  int          n_errors;
  int          checks;

  pcr_bank pcr_bank_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .locked_i(locked_i),
    .loop_track_i(loop_track_i), .crystal_clock_i(crystal_clock_i),
    .vco_clock_i(vco_clock_i), .base_clock_out_o(base_clock_out_o),
    .base_source_o(base_source_o), .loop_irq_o(loop_irq_o), .loop_enable_o(loop_enable_o),
    .vco_enable_o(vco_enable_o), .auto_mode_o(auto_mode_o),
    .capture_or_track_o(capture_or_track_o), .vco_range_power_two_o(vco_range_power_two_o),
    .feedback_divider_o(feedback_divider_o), .vco_linear_range_o(vco_linear_range_o));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Sources are unrelated to each other: crystal period 8 cycles, VCO period 6
  always @(posedge clk_i)
  begin
    xc <= xc + 3'h1;
    vc <= (vc == 3'h5) ? 3'h0 : vc + 3'h1;
    crystal_clock_i <= xc[2];
    vco_clock_i <= (vc < 3'h3);
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [11:0] seen, input logic [11:0] ex);
    checks++;
    if (seen !== ex)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  task automatic tmo();
    n_errors++;
    $display("unexpected timeout expected event seen none");
    conclude();
  endtask : tmo

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] ex);
    expq.push_back(ex);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
  endtask : rd

  task automatic settle();
    @(posedge clk_i);
    #1;
  endtask : settle

  // Output must hold still until the new source is in use
  task automatic switch_src(input logic v);
    int   n;
    int   flips;
    logic frz;
    repeat (2) settle();
    frz = base_clock_out_o;
    flips = 0;
    n = 0;
    while (base_source_o !== v)
    begin
      if (n == 100)
        tmo();
      settle();
      n++;
      if (base_source_o !== v && base_clock_out_o !== frz)
        flips++;
    end
    check("frozen_toggles", 12'(flips), 12'h0);
  endtask : switch_src

  task automatic measure(input int ex);
    int   n;
    logic p;
    for (int k = 0; k < 2; k++)
    begin
      p = base_clock_out_o;
      n = 0;
      while (base_clock_out_o === p)
      begin
        if (n == 100)
          tmo();
        settle();
        n++;
      end
    end
    check("half_period", 12'(n), 12'(ex));
  endtask : measure

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (rd_seen && expq.size() > 0)
      check("rdata_o", {4'h0, rdata_o}, {4'h0, expq.pop_front()});
    rd_seen <= rd_i;
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    tmo();
  end

  initial
  begin
    {rst_i, addr_i, wdata_i, wr_i, rd_i, locked_i, loop_track_i} = '0;
    {rd_seen, xc, vc, crystal_clock_i, vco_clock_i, n_errors, checks} = '0;
    rst_i = 1'b1;
    seed = 32'h76cc;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(PCR_ADDR_LOOP_CTRL, 8'h20);
    rd(PCR_ADDR_BANDWIDTH, 8'h00);
    rd(PCR_ADDR_DIV_HIGH, 8'h00);
    rd(PCR_ADDR_DIV_LOW, 8'h40);
    rd(PCR_ADDR_VCO_RANGE, 8'h40);
    rd(3'h5, 8'h00);
    settle();
    check("divider", feedback_divider_o, 12'h040);
    check("loop_en", 12'({loop_enable_o, vco_enable_o}), 12'h3);
    check("linear", 12'(vco_linear_range_o), 12'h040);
    check("auto", 12'(auto_mode_o), 12'h0);
    measure(8);
    $display("test reset values done");
    // Locked fields while powered
    wr(PCR_ADDR_DIV_LOW, 8'h12);
    wr(PCR_ADDR_DIV_HIGH, 8'h0f);
    wr(PCR_ADDR_VCO_RANGE, 8'h11);
    wr(PCR_ADDR_LOOP_CTRL, 8'ha1);
    rd(PCR_ADDR_LOOP_CTRL, 8'h20);
    rd(PCR_ADDR_DIV_HIGH, 8'h00);
    rd(PCR_ADDR_DIV_LOW, 8'h40);
    rd(PCR_ADDR_VCO_RANGE, 8'h40);
    wr(PCR_ADDR_LOOP_CTRL, 8'h00);
    settle();
    check("loop_off", 12'({loop_enable_o, vco_enable_o}), 12'h0);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      d = (i == 3) ? 12'h000 : seed[11:0];
      wr(PCR_ADDR_DIV_HIGH, {seed[15:12], d[11:8]});
      wr(PCR_ADDR_DIV_LOW, d[7:0]);
      rd(PCR_ADDR_DIV_HIGH, {4'h0, d[11:8]});
      settle();
      check("divider", feedback_divider_o, (d == 12'h0) ? 12'h001 : d);
    end
    for (int v = 0; v < 3; v++)
    begin
      wr(PCR_ADDR_LOOP_CTRL, 8'(v));
      rd(PCR_ADDR_LOOP_CTRL, 8'(v));
      settle();
      check("vpr", 12'(vco_range_power_two_o), 12'(v));
    end
    wr(PCR_ADDR_VCO_RANGE, seed[23:16] | 8'h01);
    rd(PCR_ADDR_VCO_RANGE, seed[23:16] | 8'h01);
    settle();
    check("linear", 12'(vco_linear_range_o), 12'(seed[23:16] | 8'h01));
    $display("test protection done");
    wr(PCR_ADDR_LOOP_CTRL, 8'h12);
    rd(PCR_ADDR_LOOP_CTRL, 8'h02);
    wr(PCR_ADDR_LOOP_CTRL, 8'h32);
    rd(PCR_ADDR_LOOP_CTRL, 8'h22);
    wr(PCR_ADDR_LOOP_CTRL, 8'h32);
    switch_src(1'b1);
    rd(PCR_ADDR_LOOP_CTRL, 8'h32);
    measure(6);
    wr(PCR_ADDR_LOOP_CTRL, 8'h02);
    switch_src(1'b0);
    rd(PCR_ADDR_LOOP_CTRL, 8'h22);
    measure(8);
    wr(PCR_ADDR_LOOP_CTRL, 8'h02);
    wr(PCR_ADDR_VCO_RANGE, 8'h00);
    wr(PCR_ADDR_LOOP_CTRL, 8'h22);
    wr(PCR_ADDR_LOOP_CTRL, 8'h32);
    rd(PCR_ADDR_LOOP_CTRL, 8'h22);
    settle();
    check("loop_en", 12'(loop_enable_o), 12'h0);
    wr(PCR_ADDR_LOOP_CTRL, 8'h02);
    wr(PCR_ADDR_VCO_RANGE, 8'h40);
    $display("test base select done");
    wr(PCR_ADDR_BANDWIDTH, 8'h20);
    rd(PCR_ADDR_BANDWIDTH, 8'h20);
    // The write that enters auto mode is still a manual write, so keep track set
    wr(PCR_ADDR_BANDWIDTH, 8'ha0);
    wr(PCR_ADDR_LOOP_CTRL, 8'ha2);
    // Lock change in each direction sets the flag; reads clear it
    for (int k = 0; k < 2; k++)
    begin
      locked_i <= (k == 0);
      loop_track_i <= (k == 0);
      repeat (10) @(posedge clk_i);
      settle();
      check("irq", 12'(loop_irq_o), 12'h1);
      check("auto", 12'(auto_mode_o), 12'h1);
      rd(PCR_ADDR_LOOP_CTRL, 8'he2);
      rd(PCR_ADDR_LOOP_CTRL, 8'ha2);
      rd(PCR_ADDR_BANDWIDTH, (k == 0) ? 8'he0 : 8'h80);
      settle();
      check("irq", 12'(loop_irq_o), 12'h0);
    end
    wr(PCR_ADDR_BANDWIDTH, 8'h00);
    rd(PCR_ADDR_BANDWIDTH, 8'h20);
    locked_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(PCR_ADDR_LOOP_CTRL, 8'h22);
    rd(PCR_ADDR_BANDWIDTH, 8'h20);
    settle();
    check("irq", 12'(loop_irq_o), 12'h0);
    check("track", 12'(capture_or_track_o), 12'h1);
    check("auto", 12'(auto_mode_o), 12'h0);
    $display("test bandwidth done");
    repeat (3) @(posedge clk_i);
    conclude();
  end

endmodule : tb_pcr_bank

`default_nettype wire
